// File: dma_chan_ctrl.sv
// Channel activation source, source flag clear and priority masking
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "dma_chan_consts.svh"

module dma_chan_ctrl (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    // CPU priority
    input  wire logic [2:0]  cpu_prio,
    // Request sources
    input  wire logic [7:0]  periph_req,
    input  wire logic        ext_req_b,
    // Transfer engine
    input  wire logic        xfer_enable,
    input  wire logic        xfer_ack,
    input  wire logic        xfer_last,
    output logic             xfer_req,
    output logic             xfer_burst,
    // Peripheral flag clear, one cycle per serviced peripheral source transfer with auto clear set
    output logic      [7:0]  periph_flag_clr,
    // Interrupts
    output logic             transfer_end_irq,
    output logic             irq
);

    dma_chan_pkg::ctrl_state_t s_q;
    dma_chan_pkg::ctrl_state_t s_d;

    logic       sel_req;
    logic [7:0] sel_onehot;
    logic       ext_req;
    logic       blocked;
    logic       trigger;
    logic       served;
    logic [2:0] ev;
    logic       wr_mode;
    logic       wr_sts;

    // Selected peripheral request
    periph_req_mux #(
        .N          (8)
    ) u_mux (
        .periph_req (periph_req),
        .sel        (s_q.psel),
        .req        (sel_req),
        .onehot     (sel_onehot)
    );

    // External request line sampling
    ext_req_sampler u_samp (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .ext_req_b  (ext_req_b),
        .edge_mode  (s_q.samp),
        .req        (ext_req)
    );

    // Priority compare; equal levels do not mask the channel
    assign blocked = s_q.pce && (cpu_prio > s_q.prio);

    // Activation source decides what starts a request
    always_comb begin
        case (s_q.src)
            `SRC_AUTO_CS:    trigger = xfer_enable;
            `SRC_AUTO_BURST: trigger = xfer_enable;
            `SRC_PERIPH:     trigger = xfer_enable && sel_req;
            `SRC_EXT:        trigger = xfer_enable && ext_req;
            default:         trigger = 1'b0;
        endcase
    end

    // Request stays pending while masked, raised when priority allows
    assign xfer_req = (s_q.fsm == dma_chan_pkg::req_pend) && xfer_enable
                      && !blocked;
    assign served   = xfer_req && xfer_ack;
    assign xfer_burst = (s_q.src == `SRC_AUTO_BURST);

    // Events for the sticky status register
    always_comb begin
        ev = `RST_EVENTS;
        ev[`EV_XFER_END] = served && xfer_last;
        ev[`EV_BLOCKED]  = (s_q.fsm == dma_chan_pkg::req_pend) && blocked;
        ev[`EV_EXT_REQ]  = (s_q.src == `SRC_EXT) && ext_req;
    end

    assign wr_mode = wr_en && (addr == `OFS_MODE);
    assign wr_sts  = wr_en && (addr == `OFS_IRQ_STS);

    // Next state: registers, flags, request sequencing, read data
    always_comb begin
        s_d = s_q;
        s_d.fclr = 8'h00;

        // Software writes; each channel instance owns its fields
        if (wr_mode) begin
            s_d.src   = wr_data[`MODE_SRC_HI:`MODE_SRC_LO];
            s_d.aclr  = wr_data[`MODE_ACLR];
            s_d.prio  = wr_data[`MODE_PRIO_HI:0];
            s_d.te_ie = wr_data[`MODE_TE_IE];
            // Only a written zero clears the flag
            if (!wr_data[`MODE_TE_FLAG]) begin
                s_d.te_flag = 1'b0;
            end
        end
        if (wr_en && (addr == `OFS_PSEL)) begin
            s_d.psel = wr_data[`PSEL_IDX_HI:0];
            s_d.samp = wr_data[`PSEL_SAMP];
        end
        if (wr_en && (addr == `OFS_CPUPRIO)) begin
            s_d.pce = wr_data[`CPUPRIO_PCE];
        end
        if (wr_en && (addr == `OFS_IRQ_MSK)) begin
            s_d.msk = wr_data[2:0];
        end
        if (wr_sts) begin
            s_d.sts = s_q.sts & ~wr_data[2:0];
        end

        // Hardware set wins over a clear in the same cycle
        s_d.sts = s_d.sts | ev;
        if (ev[`EV_XFER_END]) begin
            s_d.te_flag = 1'b1;
        end

        // Request sequencing
        case (s_q.fsm)
            dma_chan_pkg::req_idle: begin
                if (trigger) begin
                    s_d.fsm = dma_chan_pkg::req_pend;
                end
            end
            dma_chan_pkg::req_pend: begin
                if (served) begin
                    s_d.fsm = dma_chan_pkg::req_idle;
                end
            end
            default: s_d.fsm = dma_chan_pkg::req_idle;
        endcase

        // Flag clear only for the peripheral source with clear bit set
        if (served && (s_q.src == `SRC_PERIPH) && s_q.aclr) begin
            s_d.fclr = sel_onehot;
        end

        // Read data, valid the cycle after the strobe
        s_d.rdata = 32'h0000_0000;
        if (rd_en) begin
            case (addr)
                `OFS_MODE: begin
                    s_d.rdata[`MODE_SRC_HI:`MODE_SRC_LO] = s_q.src;
                    s_d.rdata[`MODE_ACLR]    = s_q.aclr;
                    s_d.rdata[4:3]           = 2'h0;
                    s_d.rdata[`MODE_PRIO_HI:0] = s_q.prio;
                    s_d.rdata[`MODE_TE_IE]   = s_q.te_ie;
                    s_d.rdata[`MODE_TE_FLAG] = s_q.te_flag;
                end
                `OFS_PSEL: begin
                    s_d.rdata[`PSEL_IDX_HI:0] = s_q.psel;
                    s_d.rdata[`PSEL_SAMP]     = s_q.samp;
                end
                `OFS_CPUPRIO: s_d.rdata[`CPUPRIO_PCE] = s_q.pce;
                `OFS_IRQ_STS: s_d.rdata[2:0] = s_q.sts;
                `OFS_IRQ_MSK: s_d.rdata[2:0] = s_q.msk;
                default:      s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; mode byte comes up all zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_q.src     <= `RST_SRC;
            s_q.aclr    <= 1'b0;
            s_q.prio    <= `RST_PRIO;
            s_q.te_ie   <= 1'b0;
            s_q.te_flag <= 1'b0;
            s_q.psel    <= 3'h0;
            s_q.samp    <= 1'b0;
            s_q.pce     <= 1'b0;
            s_q.sts     <= `RST_EVENTS;
            s_q.msk     <= `RST_EVENTS;
            s_q.fsm     <= dma_chan_pkg::req_idle;
            s_q.fclr    <= 8'h00;
            s_q.rdata   <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rd_data          = s_q.rdata;
    assign periph_flag_clr  = s_q.fclr;
    assign transfer_end_irq = s_q.te_flag && s_q.te_ie;
    assign irq              = |(s_q.sts & s_q.msk);

    // Serviced transfer from a peripheral with automatic clear
    sequence aclr_service_s;
        served && (s_q.src == `SRC_PERIPH) && s_q.aclr;
    endsequence

    // Serviced transfer from any other source
    sequence other_service_s;
        served && (s_q.src != `SRC_PERIPH);
    endsequence

    mask_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.pce && (cpu_prio > s_q.prio)) |-> !xfer_req)
        else $error("request raised while cpu priority higher");

    prio_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.fsm == dma_chan_pkg::req_pend) && xfer_enable && s_q.pce
        && (cpu_prio <= s_q.prio) |-> xfer_req)
        else $error("request held though channel priority high enough");

    no_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_q.fsm == dma_chan_pkg::req_pend) && xfer_enable && !s_q.pce
        |-> xfer_req)
        else $error("request masked with priority control off");

    flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        aclr_service_s |=> periph_flag_clr == $past(sel_onehot))
        else $error("selected peripheral flag not cleared");

    other_src_a: assert property (@(posedge mclk) disable iff (!rst_b)
        other_service_s |=> periph_flag_clr == 8'h00)
        else $error("flag cleared for non peripheral source");

    rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_en ##1 1'b1 |-> rd_data[4:3] == 2'h0)
        else $error("reserved mode bits read nonzero");

    flag_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_q.te_flag && wr_mode && wr_data[`MODE_TE_FLAG]
        |=> s_q.te_flag)
        else $error("writing one changed transfer end flag");

    te_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ev[`EV_XFER_END] && s_q.te_ie && !wr_mode
        |=> transfer_end_irq)
        else $error("transfer end interrupt not raised");

    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ev[`EV_BLOCKED] && s_q.msk[`EV_BLOCKED]
        && !(wr_en && (addr == `OFS_IRQ_MSK)) |=> irq)
        else $error("unmasked blocked event raised no interrupt");

    prio_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_mode |=> s_q.prio == $past(wr_data[2:0]))
        else $error("channel priority not taken from write");

endmodule

// File: dma_chan_consts.svh
// Register offsets, field positions and reset values of the channel
`ifndef DMA_CHAN_CONSTS_SVH
`define DMA_CHAN_CONSTS_SVH

// Register byte offsets
`define OFS_MODE       8'h00
`define OFS_PSEL       8'h04
`define OFS_CPUPRIO    8'h08
`define OFS_IRQ_STS    8'h0C
`define OFS_IRQ_MSK    8'h10

// Channel mode register fields
`define MODE_SRC_HI    7
`define MODE_SRC_LO    6
`define MODE_ACLR      5
`define MODE_PRIO_HI   2
`define MODE_TE_IE     8
`define MODE_TE_FLAG   16

// Other register fields
`define PSEL_IDX_HI    2
`define PSEL_SAMP      8
`define CPUPRIO_PCE    0

// Activation source codes
`define SRC_AUTO_CS    2'h0
`define SRC_AUTO_BURST 2'h1
`define SRC_PERIPH     2'h2
`define SRC_EXT        2'h3

// Interrupt event bits
`define EV_XFER_END    0
`define EV_BLOCKED     1
`define EV_EXT_REQ     2

// Reset values
`define RST_SRC        2'h0
`define RST_PRIO       3'h0
`define RST_EVENTS     3'h0

`endif

// File: dma_chan_pkg.sv
// Types shared by the channel request and priority logic
package dma_chan_pkg;

    typedef enum logic [0:0] {
        req_idle,
        req_pend
    } req_state_t;

    // All state of the channel control module
    typedef struct packed {
        logic [1:0]  src;
        logic        aclr;
        logic [2:0]  prio;
        logic        te_ie;
        logic        te_flag;
        logic [2:0]  psel;
        logic        samp;
        logic        pce;
        logic [2:0]  sts;
        logic [2:0]  msk;
        req_state_t  fsm;
        logic [7:0]  fclr;
        logic [31:0] rdata;
    } ctrl_state_t;

    // State of the external request sampler
    typedef struct packed {
        logic prev_b;
    } samp_state_t;

endpackage

// File: ext_req_sampler.sv
// External request line sampler, low level or falling edge
`timescale 1ns/1ps
`include "dma_chan_consts.svh"

module ext_req_sampler (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Request line and sampling choice
    input  wire logic ext_req_b,
    input  wire logic edge_mode,
    // Sampled request
    output logic      req
);

    dma_chan_pkg::samp_state_t s_q;
    dma_chan_pkg::samp_state_t s_d;

    // Remember the previous line level for edge detection
    always_comb begin
        s_d        = s_q;
        s_d.prev_b = ext_req_b;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_q.prev_b <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Level mode asks while low; edge mode asks once per fall
    assign req = edge_mode ? (s_q.prev_b && !ext_req_b)
                           : !ext_req_b;

    edge_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
        edge_mode && req |=> !req)
        else $error("edge sampled request lasted more than one cycle");

endmodule

// File: periph_req_mux.sv
// Selects one peripheral request and decodes its flag clear
`timescale 1ns/1ps

module periph_req_mux #(
    parameter int N = 8
) (
    // Peripheral side
    input  wire logic [N-1:0]         periph_req,
    input  wire logic [$clog2(N)-1:0] sel,
    // Selected request and one-hot of the selection
    output logic                      req,
    output logic [N-1:0]              onehot
);

    // Only the selected peripheral may trigger the channel
    always_comb begin
        req    = periph_req[sel];
        onehot = '0;
        onehot[sel] = 1'b1;
    end

endmodule

// File: xfer_far_model.sv
// Transfer engine and peripheral flag model at the channel's far side
`timescale 1ns/1ps

module xfer_far_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Bench controls
    input  wire logic       slow,
    input  wire logic [7:0] flag_set,
    // Channel side
    input  wire logic       xfer_req,
    input  wire logic [7:0] periph_flag_clr,
    output logic            xfer_ack,
    output logic      [7:0] periph_req
);
    logic [1:0] wait_q;
    logic [7:0] flag_q;

    // Engine acks for one cycle, at once or after a four cycle wait
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            xfer_ack <= 1'b0;
            wait_q   <= 2'h0;
        end else begin
            xfer_ack <= xfer_req && !xfer_ack && (!slow || wait_q == 2'h3);
            wait_q   <= (xfer_req && !xfer_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end

    // Flags stay set until cleared; the clear acts at once, no re-request
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flag_q <= 8'h00;
        end else begin
            flag_q <= (flag_q | flag_set) & ~periph_flag_clr;
        end
    end
    assign periph_req = flag_q & ~periph_flag_clr;
endmodule

// File: dma_channel_request_priority_tb_top.sv
// Self-checking bench for the channel request and priority block
`timescale 1ns/1ps

module dma_channel_request_priority_tb_top;
    logic        mclk, rst_b, wr_en, rd_en, ext_req_b, slow, rd_seen;
    logic [7:0]  addr, flag_set, periph_req, periph_flag_clr;
    logic [31:0] wr_data, rd_data, rng;
    logic [2:0]  cpu_prio, p, c;
    logic        xfer_enable, xfer_ack, xfer_last, xfer_req, xfer_burst;
    logic        transfer_end_irq, irq;
    logic [31:0] rq[$];
    logic [7:0]  cq[$];
    int          bad_count, n_tests, n;

    dma_chan_ctrl u_dma_chan_ctrl (.mclk, .rst_b, .addr, .wr_data, .wr_en,
        .rd_en, .rd_data, .cpu_prio, .periph_req, .ext_req_b, .xfer_enable,
        .xfer_ack, .xfer_last, .xfer_req, .xfer_burst, .periph_flag_clr,
        .transfer_end_irq, .irq);
    xfer_far_model u_xfer_far_model (.mclk, .rst_b, .slow, .flag_set,
        .xfer_req, .periph_flag_clr, .xfer_ack, .periph_req);

    // Clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        rq.push_back(e);
        @(posedge mclk);
        rd_en <= 1'b0;
    endtask

    task automatic reset_dut();
        @(posedge mclk);
        rst_b <= 1'b0;
        xfer_enable <= 1'b0;
        ext_req_b <= 1'b1;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge mclk);
        flag_set <= m;
        @(posedge mclk);
        flag_set <= 8'h00;
    endtask

    // Counts acks over a window long enough for the slow engine
    task automatic acks(input int k);
        n = 0;
        repeat (k) begin
            @(posedge mclk);
            if (xfer_ack === 1'b1) n++;
        end
    endtask

    // Read data and flag clears are matched to the oldest note
    always @(posedge mclk) begin
        if (rd_seen) chk("rd_data", rd_data, rq.pop_front());
        if (rst_b && periph_flag_clr !== 8'h00)
            chk("flag_clr", {24'h0, periph_flag_clr},
                {24'h0, cq.size() ? cq.pop_front() : 8'h00});
        rd_seen <= rd_en;
    end

    // Tests need about 530 cycles; a hang is cut well after that
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        stop_test();
    end

    initial begin
        {wr_en, rd_en, xfer_enable, xfer_last, slow, rd_seen} = '0;
        // Line idles high; reset is held low until reset_dut releases it
        {rst_b, ext_req_b} = 2'b01;
        {addr, flag_set, cpu_prio, wr_data} = 51'h0;
        rng = 32'h0000_0024;
        reset_dut();
        // Reset values, reserved bits and an unmapped place
        for (int a = 0; a < 6; a++) rd(8'(a * 4), 32'h0000_0000);
        wr(8'h00, 32'hFFFF_FFFF);
        wr(8'h04, 32'hFFFF_FFFF);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_01E7);
        rd(8'h04, 32'h0000_0107);
        rd(8'h14, 32'h0000_0000);
        $display("registers done");
        // Every source, level and edge sampling; the drawn slow bit is zero each time, so the engine is prompt
        for (int s = 0; s < 5; s++) begin
            reset_dut();
            rng = xs(rng);
            slow <= rng[0];
            wr(8'h04, {23'h0, s == 4, 5'h0, 3'h3});
            wr(8'h00, {24'h0, (s > 3) ? 2'h3 : 2'(s), 6'h00});
            if (s == 2) pulse(8'h08);
            @(posedge mclk);
            xfer_enable <= 1'b1;
            ext_req_b <= (s < 3);
            chk("burst", {31'h0, xfer_burst}, {31'h0, s == 1});
            acks(12);
            chk("acks", {31'h0, n > 0}, 32'h0000_0001);
            if (s == 2) chk("flag", {24'h0, periph_req}, 32'h8);
        end
        $display("sources done");
        // Auto clear acts for the peripheral source only
        for (int s = 0; s < 4; s++) begin
            reset_dut();
            rng = xs(rng);
            wr(8'h04, {29'h0, rng[2:0]});
            wr(8'h00, {24'h0, 2'(s), 6'h20});
            if (s == 2) cq.push_back(8'h01 << rng[2:0]);
            pulse(8'h01 << rng[2:0]);
            @(posedge mclk);
            xfer_enable <= 1'b1;
            ext_req_b <= (s != 3);
            acks(12);
            chk("flags", {24'h0, periph_req},
                s == 2 ? 32'h0 : {24'h0, 8'h01 << rng[2:0]});
        end
        $display("auto clear done");
        // Channel against CPU priority; equal passes, blocked case last
        reset_dut();
        wr(8'h08, 32'h0000_0001);
        for (int k = 0; k < 9; k++) begin
            rng = xs(rng);
            p = (k == 8) ? 3'h0 : rng[2:0];
            c = (k == 8) ? 3'h7 : (k == 0) ? p : rng[5:3];
            wr(8'h00, {29'h0, p});
            @(posedge mclk);
            cpu_prio <= c;
            xfer_enable <= 1'b1;
            acks(12);
            chk("acks", {31'h0, n > 0}, {31'h0, c <= p});
            @(posedge mclk);
            xfer_enable <= 1'b0;
        end
        chk("irq", {31'h0, irq}, 32'h0);
        @(posedge mclk);
        xfer_enable <= 1'b1;
        cpu_prio <= 3'h0;
        acks(12);
        chk("held", {31'h0, n > 0}, 32'h1);
        wr(8'h08, 32'h0000_0000);
        cpu_prio <= 3'h7;
        acks(12);
        chk("free", {31'h0, n > 0}, 32'h1);
        xfer_enable <= 1'b0;
        // Blocked event: mask, write zero, write one
        wr(8'h10, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(8'h0C, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(8'h0C, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("priority done");
        // Transfer end flag and its interrupt
        reset_dut();
        wr(8'h00, 32'h0000_0100);
        @(posedge mclk);
        xfer_last <= 1'b1;
        xfer_enable <= 1'b1;
        acks(12);
        xfer_enable <= 1'b0;
        xfer_last <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("te_irq", {31'h0, transfer_end_irq}, 32'h1);
        wr(8'h00, 32'h0001_0000);
        rd(8'h00, 32'h0001_0000);
        chk("te_irq", {31'h0, transfer_end_irq}, 32'h0);
        wr(8'h00, 32'h0000_0100);
        rd(8'h00, 32'h0000_0100);
        chk("te_irq", {31'h0, transfer_end_irq}, 32'h0);
        $display("transfer end done");
        repeat (3) @(posedge mclk);
        stop_test();
    end
endmodule
